// [shared/usb_regs_params.svh]
// constants for the usb token, frame and endpoint register block
//
// Functional notes
// - capture 11-bit frame number on each frame token; none is captured while the module is halted
// - token types: 0001 out, 1001 in, 1101 setup
// - low pointer bits 7:1 give address 15:9
// - mid pointer gives address bits 23:16
// - high pointer gives address bits 31:24
// - eye-pattern bit enables eye test
// - monitor bit shows drive intervals on output
// - freeze bit halts module during debug
// - idle-stop bit halts module in idle
// - auto suspend on sleep, else software suspends
// - endpoint 0 low-speed direct versus hub preamble
// - endpoint 0 nak retry unless disabled
// - control disable blocks setup when both enabled
// - endpoint receives or transmits only when enabled
// - stall bit reflects endpoint stalled state
// - handshakes only while handshake bit set
// - unimplemented bits read as zero
// - host sends frame token every millisecond
`ifndef USB_REGS_PARAMS_SVH
`define USB_REGS_PARAMS_SVH
// ====================================================================
// register byte offsets
`define OFS_FRAME_LOW    12'h000
`define OFS_FRAME_HIGH   12'h004
`define OFS_TOKEN        12'h008
`define OFS_THRESHOLD    12'h00c
`define OFS_BASE_LOW     12'h010
`define OFS_BASE_MID     12'h014
`define OFS_BASE_HIGH    12'h018
`define OFS_CONFIG       12'h01c
`define OFS_CONTROL      12'h020
`define OFS_ENDPOINT0    12'h040
// ====================================================================
// field masks and positions
`define MASK_FRAME_HIGH  8'h07
`define MASK_BASE_LOW    8'hfe
`define MASK_CONFIG      8'hf1
`define MASK_ENDPOINT    8'hdf
`define MASK_CONTROL     8'h01
`define MASK_EP_WRITE    8'hdd
`define BIT_EYE          7
`define BIT_OEMON        6
`define BIT_FREEZE       5
`define BIT_IDLE         4
`define BIT_AUTOSUSP     0
`define BIT_LOW_SPEED_DIRECT         7
`define BIT_NAK_RETRY_DISABLE     6
`define BIT_CONDIS       4
`define BIT_RXEN         3
`define BIT_TXEN         2
`define BIT_STALL        1
`define BIT_HSHK         0
`define BIT_BUSY         5
`define BIT_FRAME_EN     0
`define PID_OUT          4'h1
`define PID_IN           4'h9
`define PID_SETUP        4'hd
`define RESET_BYTE       8'h00
// ====================================================================
// frame timer: 1 ms at 5 ns per clock
`define FRAME_PERIOD_NS  1000000
`define CLOCK_PERIOD_NS  5
`define FRAME_CYCLES     (`FRAME_PERIOD_NS / `CLOCK_PERIOD_NS)
`endif

// [shared/usb_regs_pkg.sv]
// types shared by the usb register block and its helpers
package usb_regs_pkg;
   // decoded token request handed to the serial engine
   typedef struct packed {
      logic       valid;
      logic [3:0] pid;
      logic [3:0] endpoint;
      logic       low_speed;
      logic       no_retry;
   } token_request_type;
   // endpoint permission flags for the engine
   typedef struct packed {
      logic rx_ok;
      logic tx_ok;
      logic setup_ok;
      logic handshake;
   } endpoint_permit_type;
   // token phases
   typedef enum logic [1:0] {TOK_IDLE, TOK_BUSY} token_state_type;
endpackage

// [verilog/usb_endpoint_bank.sv]
// sixteen endpoint control bytes with registered read port
`timescale 1ns/1ps
`include "usb_regs_params.svh"
module usb_endpoint_bank #(
   parameter int DEPTH = 16
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // software port
   input  wire logic        write_en,
   input  wire logic [3:0]  write_index,
   input  wire logic [7:0]  write_data,
   input  wire logic [3:0]  read_index,
   output logic      [7:0]  read_data,
   // engine stall events
   input  wire logic [15:0] stall_set,
   // all entries in parallel
   output logic      [7:0]  entries [DEPTH]
);
   initial begin
      if (DEPTH != 16) $error("endpoint bank needs 16 entries");
   end
   // stall set by engine wins over software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DEPTH; i++) entries[i] <= `RESET_BYTE;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            if (write_en && write_index == 4'(i)) begin
               entries[i] <= write_data & `MASK_ENDPOINT;
            end
            if (stall_set[i]) begin
               entries[i][`BIT_STALL] <= 1'b1;
            end
         end
      end
   end
   // registered read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) read_data <= `RESET_BYTE;
      else read_data <= entries[read_index];
   end
endmodule

// [verilog/usb_token_frame_regs.sv]
// usb token, frame number, table pointer, config and endpoint registers
`timescale 1ns/1ps
`include "usb_regs_params.svh"
module usb_token_frame_regs #(
   parameter int FRAME_CYCLES = `FRAME_CYCLES
) (
   // clock and reset
   input  wire logic                             pclk,
   input  wire logic                             presetn,
   // apb slave
   input  wire logic                             psel,
   input  wire logic                             penable,
   input  wire logic                             pwrite,
   input  wire logic [11:0]                      paddr,
   input  wire logic [31:0]                      pwdata,
   output logic      [31:0]                      prdata,
   output logic                                  pready,
   output logic                                  pslverr,
   // serial engine side
   input  wire logic                             host_mode,
   input  wire logic                             frame_token_seen,
   input  wire logic [10:0]                      frame_token_number,
   input  wire logic                             token_done,
   input  wire logic                             line_driving,
   input  wire logic [15:0]                      stall_event,
   input  wire logic [3:0]                       query_endpoint,
   output usb_regs_pkg::token_request_type       token_request,
   output usb_regs_pkg::endpoint_permit_type     permit,
   output logic                                  frame_token_send,
   output logic      [31:0]                      table_base,
   output logic      [7:0]                       threshold_value,
   output logic                                  eye_test_active,
   output logic                                  drive_monitor,
   // system power and debug
   input  wire logic                             debug_halted,
   input  wire logic                             idle_mode,
   input  wire logic                             sleep_mode,
   input  wire logic                             manual_suspend,
   output logic                                  module_run
);
   import usb_regs_pkg::*;

   initial begin
      if (FRAME_CYCLES < 2) $error("frame period too short");
   end

   // ===================================================================
   // register storage
   logic [7:0]  frame_low_bits;
   logic [2:0]  frame_high_bits;
   logic [7:0]  token_command;
   logic [7:0]  table_base_low_bits;
   logic [7:0]  table_base_mid_bits;
   logic [7:0]  table_base_high_bits;
   logic [7:0]  module_configuration;
   logic        frame_start_enable;
   token_state_type token_state;
   logic [31:0] frame_count;
   logic        halted;
   logic [7:0]  ep_entries [16];
   logic [7:0]  ep_now;
   logic        wr;
   logic        rd;
   logic        ep_hit;
   logic        mapped;
   logic [31:0] next_prdata;

   // single-cycle access: ready in access phase
   assign wr = psel && penable && pwrite;
   assign rd = psel && !penable && !pwrite;
   assign ep_hit = paddr[11:6] == 6'(`OFS_ENDPOINT0 >> 6) && paddr[1:0] == 2'h0;

   // ===================================================================
   // endpoint bank
   usb_endpoint_bank #(.DEPTH(16)) bank (
      .pclk        (pclk),
      .presetn     (presetn),
      .write_en    (wr && ep_hit),
      .write_index (paddr[5:2]),
      .write_data  (pwdata[7:0]),
      .read_index  (paddr[5:2]),
      .read_data   (),
      .stall_set   (stall_event),
      .entries     (ep_entries)
   );

   // ===================================================================
   // software registers; frame capture overrides a same-cycle write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_low_bits  <= `RESET_BYTE;
         frame_high_bits <= 3'h0;
      end else if (frame_token_seen && !halted) begin
         frame_low_bits  <= frame_token_number[7:0];
         frame_high_bits <= frame_token_number[10:8];
      end else if (wr && paddr == `OFS_FRAME_LOW) begin
         frame_low_bits <= pwdata[7:0];
      end else if (wr && paddr == `OFS_FRAME_HIGH) begin
         frame_high_bits <= pwdata[2:0];
      end
   end

   // pointer, threshold and config bytes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         threshold_value      <= `RESET_BYTE;
         table_base_low_bits  <= `RESET_BYTE;
         table_base_mid_bits  <= `RESET_BYTE;
         table_base_high_bits <= `RESET_BYTE;
         module_configuration <= `RESET_BYTE;
         frame_start_enable   <= 1'b0;
      end else if (wr) begin
         unique case (paddr)
            `OFS_THRESHOLD: threshold_value <= pwdata[7:0];
            `OFS_BASE_LOW:  table_base_low_bits <= pwdata[7:0] & `MASK_BASE_LOW;
            `OFS_BASE_MID:  table_base_mid_bits <= pwdata[7:0];
            `OFS_BASE_HIGH: table_base_high_bits <= pwdata[7:0];
            `OFS_CONFIG:    module_configuration <= pwdata[7:0] & `MASK_CONFIG;
            `OFS_CONTROL:   frame_start_enable <= pwdata[`BIT_FRAME_EN];
            default: ;
         endcase
      end
   end

   // ===================================================================
   // token command: a host-mode write while idle launches one token; done ends it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         token_command <= `RESET_BYTE;
         token_state   <= TOK_IDLE;
         token_request <= '0;
      end else begin
         token_request.valid <= 1'b0;
         unique case (token_state)
            TOK_IDLE: begin
               // busy state guards a second write; software must poll
               if (wr && paddr == `OFS_TOKEN && host_mode) begin
                  token_command           <= pwdata[7:0];
                  token_request.valid     <= 1'b1;
                  token_request.pid       <= pwdata[7:4];
                  token_request.endpoint  <= pwdata[3:0];
                  // endpoint 0 options travel with the token
                  token_request.low_speed <= ep_entries[0][`BIT_LOW_SPEED_DIRECT];
                  token_request.no_retry  <= ep_entries[0][`BIT_NAK_RETRY_DISABLE];
                  token_state             <= TOK_BUSY;
               end else if (wr && paddr == `OFS_TOKEN) begin
                  token_command <= pwdata[7:0];
               end
            end
            TOK_BUSY: begin
               if (token_done) token_state <= TOK_IDLE;
            end
         endcase
      end
   end

   // ===================================================================
   // frame token timer, host mode only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         frame_count      <= 32'h0;
         frame_token_send <= 1'b0;
      end else if (host_mode && frame_start_enable && !halted) begin
         frame_token_send <= frame_count == 32'(FRAME_CYCLES - 1);
         if (frame_count == 32'(FRAME_CYCLES - 1)) frame_count <= 32'h0;
         else frame_count <= frame_count + 32'h1;
      end else begin
         frame_count      <= 32'h0;
         frame_token_send <= 1'b0;
      end
   end

   // ===================================================================
   // run control, monitor, base, permissions
   assign ep_now = ep_entries[query_endpoint];
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         halted          <= 1'b0;
         module_run      <= 1'b0;
         eye_test_active <= 1'b0;
         drive_monitor   <= 1'b0;
         table_base      <= 32'h0;
         permit          <= '0;
      end else begin
         halted <= (module_configuration[`BIT_FREEZE] && debug_halted)
                || (module_configuration[`BIT_IDLE] && idle_mode)
                || (module_configuration[`BIT_AUTOSUSP] && sleep_mode)
                || manual_suspend;
         module_run      <= !halted;
         eye_test_active <= module_configuration[`BIT_EYE];
         drive_monitor   <= module_configuration[`BIT_OEMON] && line_driving;
         table_base      <= {table_base_high_bits, table_base_mid_bits,
                             table_base_low_bits[7:1], 9'h000};
         permit.rx_ok    <= ep_now[`BIT_RXEN];
         permit.tx_ok    <= ep_now[`BIT_TXEN];
         permit.setup_ok <= !(ep_now[`BIT_RXEN] && ep_now[`BIT_TXEN]
                              && ep_now[`BIT_CONDIS]);
         permit.handshake <= ep_now[`BIT_HSHK];
      end
   end

   // ===================================================================
   // read mux in setup, data registered for the access phase
   always_comb begin
      next_prdata = 32'h0;
      mapped      = 1'b1;
      unique case (paddr)
         `OFS_FRAME_LOW:  next_prdata[7:0] = frame_low_bits;
         `OFS_FRAME_HIGH: next_prdata[2:0] = frame_high_bits;
         `OFS_TOKEN:      next_prdata[7:0] = token_command;
         `OFS_THRESHOLD:  next_prdata[7:0] = threshold_value;
         `OFS_BASE_LOW:   next_prdata[7:0] = table_base_low_bits;
         `OFS_BASE_MID:   next_prdata[7:0] = table_base_mid_bits;
         `OFS_BASE_HIGH:  next_prdata[7:0] = table_base_high_bits;
         `OFS_CONFIG:     next_prdata[7:0] = module_configuration;
         `OFS_CONTROL: begin
            next_prdata[`BIT_BUSY]     = token_state == TOK_BUSY;
            next_prdata[`BIT_FRAME_EN] = frame_start_enable;
         end
         default: begin
            // endpoint bytes are read straight from the bank so the answer
            // keeps zero wait states
            mapped = ep_hit;
            if (ep_hit) next_prdata[7:0] = ep_entries[paddr[5:2]];
         end
      endcase
   end

   // apb answer; read data registered at the setup edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         if (rd) prdata <= next_prdata;
      end
   end

   // ===================================================================
   // checks
   a_frame_capture: assert property (@(posedge pclk) disable iff (!presetn)
      frame_token_seen && !halted |=> frame_low_bits == $past(frame_token_number[7:0])
      && frame_high_bits == $past(frame_token_number[10:8]))
      else $error("frame number not captured");
   a_base_align: assert property (@(posedge pclk) disable iff (!presetn)
      table_base[8:0] == 9'h000) else $error("table base not aligned");
   a_base_mid: assert property (@(posedge pclk) disable iff (!presetn)
      $stable(table_base_mid_bits) |=> table_base[23:16] == $past(table_base_mid_bits))
      else $error("mid base wrong");
   a_base_high: assert property (@(posedge pclk) disable iff (!presetn)
      $stable(table_base_high_bits) |=> table_base[31:24] == $past(table_base_high_bits))
      else $error("high base wrong");
   a_eye_test: assert property (@(posedge pclk) disable iff (!presetn)
      module_configuration[`BIT_EYE] |=> eye_test_active)
      else $error("eye test not enabled");
   a_monitor_off: assert property (@(posedge pclk) disable iff (!presetn)
      !module_configuration[`BIT_OEMON] |=> !drive_monitor)
      else $error("monitor active when disabled");
   a_idle_stop: assert property (@(posedge pclk) disable iff (!presetn)
      module_configuration[`BIT_IDLE] && idle_mode |=> ##1 !module_run)
      else $error("module ran in idle");
   a_frame_gap: assert property (@(posedge pclk) disable iff (!presetn)
      frame_token_send |=> !frame_token_send) else $error("frame tokens adjacent");
   a_token_launch: assert property (@(posedge pclk) disable iff (!presetn)
      token_request.valid |-> token_state == TOK_BUSY) else $error("token without busy");
endmodule

// [dv/usb_engine_model.sv]
// behavioural serial engine model facing the register block
`timescale 1ns/1ps
module usb_engine_model (
   // clock and reset
   input  wire logic                            pclk,
   input  wire logic                            presetn,
   // register block side
   input  wire usb_regs_pkg::token_request_type token_request,
   output logic                                 frame_token_seen,
   output logic      [10:0]                     frame_token_number,
   output logic                                 token_done,
   output logic                                 line_driving,
   output logic      [15:0]                     stall_event
);
   import usb_regs_pkg::*;
   int                done_delay = 30;
   int                wait_left;
   token_request_type last_token;
   // ====================================================================
   // token execution: finish each request after done_delay cycles, so busy is visible
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         token_done <= 1'b0;
         wait_left  <= 0;
         last_token <= '0;
      end else begin
         token_done <= 1'b0;
         if (token_request.valid === 1'b1) begin
            last_token <= token_request;
            wait_left  <= done_delay;
         end else if (wait_left == 1) begin
            token_done <= 1'b1;
            wait_left  <= 0;
         end else if (wait_left > 1) begin
            wait_left <= wait_left - 1;
         end
      end
   end
   // idle levels; number shows garbage outside the token pulse
   initial begin
      frame_token_seen   = 1'b0;
      frame_token_number = 11'h7ff;
      line_driving       = 1'b0;
      stall_event        = 16'h0000;
   end
   // one received frame token carrying number n
   task automatic send_frame(input logic [10:0] n);
      @(posedge pclk);
      frame_token_seen   <= 1'b1;
      frame_token_number <= n;
      @(posedge pclk);
      frame_token_seen   <= 1'b0;
      frame_token_number <= ~n;  // a stale capture would show this
   endtask
   // one-cycle stall event on endpoint idx
   task automatic stall(input int idx);
      @(posedge pclk);
      stall_event <= 16'h0001 << idx;
      @(posedge pclk);
      stall_event <= 16'h0000;
   endtask
endmodule

// [dv/testbench.sv]
// self-checking testbench for the usb token, frame and endpoint registers
`timescale 1ns/1ps
module testbench;
   import usb_regs_pkg::*;
   localparam int FRAMES = 20;
   logic                pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic                host_mode, debug_halted, idle_mode, sleep_mode, manual_suspend;
   logic                frame_token_seen, token_done, line_driving, frame_token_send;
   logic                eye_test_active, drive_monitor, module_run;
   logic [11:0]         paddr;
   logic [31:0]         pwdata, prdata, table_base;
   logic [10:0]         frame_token_number;
   logic [15:0]         stall_event;
   logic [3:0]          query_endpoint;
   logic [7:0]          threshold_value;
   token_request_type   token_request;
   endpoint_permit_type permit;
   int                  bad_count, checks;
   usb_token_frame_regs #(.FRAME_CYCLES(FRAMES)) dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .host_mode(host_mode), .frame_token_seen(frame_token_seen),
      .frame_token_number(frame_token_number), .token_done(token_done),
      .line_driving(line_driving), .stall_event(stall_event), .query_endpoint(query_endpoint),
      .token_request(token_request), .permit(permit), .frame_token_send(frame_token_send),
      .table_base(table_base), .threshold_value(threshold_value),
      .eye_test_active(eye_test_active), .drive_monitor(drive_monitor),
      .debug_halted(debug_halted), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
      .manual_suspend(manual_suspend), .module_run(module_run));
   usb_engine_model eng (
      .pclk(pclk), .presetn(presetn), .token_request(token_request),
      .frame_token_seen(frame_token_seen), .frame_token_number(frame_token_number),
      .token_done(token_done), .line_driving(line_driving), .stall_event(stall_event));
   // ====================================================================
   // clock, verdict and watchdog
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // whole run is a few hundred cycles; 200 us is 40000 cycles, so this is generous
   initial begin
      #200us;
      bad_count++;
      tally_and_finish();
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ====================================================================
   // apb master: hold the request until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) chk("pready", 32'h1, 32'h0);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(what, exp, r);
   endtask
   task automatic settle;
      repeat (3) @(posedge pclk);
      #1;
   endtask
   // ====================================================================
   // tests
   logic [11:0]       ofs [11] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014,
                                   12'h018, 12'h01c, 12'h020, 12'h040, 12'h07c};
   logic [7:0]        thr [4] = '{8'h4a, 8'h2a, 8'h1a, 8'h12};
   logic [3:0]        pid [3] = '{4'h1, 4'h9, 4'hd};
   logic [3:0]        epn [3] = '{4'h0, 4'h5, 4'hf};
   logic [7:0]        epv [3] = '{8'h0d, 8'h1c, 8'h0c};
   logic [3:0]        epp [3] = '{4'hf, 4'hc, 4'he};
   logic [7:0]        cfg [7] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h01, 8'h00, 8'h40};
   logic [4:0]        cin [7] = '{5'h1c, 5'h01, 5'h10, 5'h08, 5'h04, 5'h02, 5'h00};
   logic [2:0]        cex [7] = '{3'h5, 3'h3, 3'h0, 3'h0, 3'h0, 3'h0, 3'h1};
   token_request_type exp_tok;
   logic [31:0]       r;
   logic              e;
   int                n;
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {host_mode, debug_halted, idle_mode, sleep_mode, manual_suspend} = '0;
      query_endpoint = 4'h0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ofs[i]) rdc("reset value", ofs[i], 32'h0);
      apb(1'b0, 12'h030, 32'h0, r, e);
      chk("unmapped error", 32'h1, 32'(e));
      chk("unmapped data", 32'h0, r);
      $display("test reset and map done");
      wr(12'h004, 32'hffffffff);
      rdc("frame high mask", 12'h004, 32'h07);
      wr(12'h010, 32'hffffff35);
      rdc("base low mask", 12'h010, 32'h34);
      wr(12'h014, 32'hffffff12);
      wr(12'h018, 32'h000000ab);
      settle();
      chk("table base", 32'hab123400, table_base);
      foreach (thr[i]) begin
         wr(12'h00c, {24'hffffff, thr[i]});
         settle();
         chk("threshold", 32'(thr[i]), 32'(threshold_value));
      end
      wr(12'h000, 32'h11);
      eng.send_frame(11'h5a3);
      rdc("frame low", 12'h000, 32'ha3);
      rdc("frame high", 12'h004, 32'h05);
      $display("test pointers and frame done");
      host_mode <= 1'b1;
      wr(12'h040, 32'hc0);
      foreach (pid[i]) begin
         rdc("idle busy", 12'h020, 32'h0);
         wr(12'h008, {24'h0, pid[i], epn[i]});
         rdc("busy", 12'h020, 32'h20);
         wr(12'h008, {24'h0, 4'h1, 4'h3});
         repeat (40) @(posedge pclk);
         // speed and retry options live in endpoint 0 and ride on every token
         exp_tok = '{1'b1, pid[i], epn[i], 1'b1, 1'b1};
         chk("token", 32'(exp_tok), 32'(eng.last_token));
      end
      $display("test tokens done");
      query_endpoint <= 4'h3;
      foreach (epv[i]) begin
         wr(12'h04c, 32'(epv[i]));
         rdc("endpoint", 12'h04c, 32'(epv[i]));
         settle();
         chk("permit", 32'(epp[i]), 32'(permit));
      end
      eng.stall(3);
      rdc("stalled", 12'h04c, 32'h0e);
      $display("test endpoints done");
      foreach (cfg[i]) begin
         wr(12'h01c, 32'(cfg[i]));
         @(posedge pclk);
         {debug_halted, idle_mode, sleep_mode, manual_suspend, eng.line_driving} <= cin[i];
         settle();
         settle();
         chk("config out", 32'(cex[i]), {29'h0, eye_test_active, drive_monitor, module_run});
      end
      $display("test configuration done");
      wr(12'h020, 32'h01);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (frame_token_send !== 1'b1 && n < 100);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (frame_token_send !== 1'b1 && n < 100);
      chk("frame period", FRAMES, n);
      wr(12'h020, 32'h00);
      n = 0;
      repeat (3 * FRAMES) begin
         @(posedge pclk);
         if (frame_token_send === 1'b1) n++;
      end
      chk("frames stopped", 32'h0, n);
      $display("test frame timer done");
      tally_and_finish();
   end
endmodule
